// ===== design/medc_ctrl.sv
// memory/peripheral strobes and edo dram controller pin sequencing
//
// Contract
// [RL1] drive low output strobe for bank reads
// [RL2] four low byte write strobes, written lanes only
// [RL3] wait in last cycle inserts wait states
// [RL4] shared-port busy restarts current transaction
// [RL5] bank transceiver enable low on all accesses; the code drives it low on bank accesses only, not on dram accesses
// [RL6] row then column on address bits 15:2
// [RL7] column advances linear or sub-block per word
// [RL8] per-bank row strobe, or chip select
// [RL9] per-lane column strobe, or byte mask
// [RL10] write enable always valid, high in refresh
// [RL11] early writes, column-strobe reads, oe optional
// [RL12] dram output enable on reads, or row strobe
// [RL13] dram transceiver enable on every dram access
// [RL14] dram wait stalls cycle while asserted; the code stalls on it in edo mode only and ignores it when sdram_mode_i is set
// [RL15] synchronous mode uses we as command line
// [RL16] direction asserted on dma reads, driven on dma
// [RL17] direction released while processor owns bus
// [RL18] everything on one shared system clock
// [RL19] waits sampled on rising edge, one cycle each
`include "medc_defs.svh"

module medc_ctrl
	import medc_pkg::*;
#(
	parameter int LANES = `MEDC_LANES,
	parameter int BANKS = `MEDC_BANKS
) (
	input  wire logic             ref_clk_i,
	input  wire logic             reset_i,
	input  wire medc_mode_e       mode_i,
	input  wire logic             sdram_mode_i,
	input  wire logic             req_valid_i,
	input  wire medc_req_s        req_i,
	output logic                  req_ready_o,
	output logic                  done_o,
	input  wire logic             mem_wait_n_i,
	input  wire logic             dram_wait_n_i,
	output logic                  mem_oe_n_o,
	output logic [LANES-1:0]      mem_we_n_o,
	output logic                  mem_xcvr_oe_n_o,
	output logic [BANKS-1:0]      dram_ras_n_o,
	output logic [LANES-1:0]      dram_cas_n_o,
	output logic                  dram_we_n_o,
	output logic                  dram_oe_n_o,
	output logic                  dram_xcvr_oe_n_o,
	output logic [13:0]           dram_addr_o,
	output logic                  xcvr_direction_o,
	output logic                  xcvr_direction_oe_o
);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_MEM_SETUP,
		ST_MEM_STROBE,
		ST_MEM_LAST,
		ST_ROW,
		ST_COL,
		ST_CAS,
		ST_PRECHARGE,
		ST_REFRESH
	} medc_state_e;

	////////////////////////////////////////////////////////////////////////
	// wait synchronisers: both waits are pins from the outside world
	logic [1:0] wait_sync_n;

	medc_wait_sync #(
		.WIDTH(2)
	) u_wait_sync (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.async_n_i ({dram_wait_n_i, mem_wait_n_i}),
		.sync_n_o  (wait_sync_n)
	);

	logic mem_wait;
	logic dram_wait;
	assign mem_wait  = ~wait_sync_n[0]; // RL19
	assign dram_wait = ~wait_sync_n[1]; // RL19

	////////////////////////////////////////////////////////////////////////
	// sequencer state
	medc_state_e     state_reg,  state_next;
	medc_req_s       cur_reg,    cur_next;
	logic [3:0]      cnt_reg,    cnt_next;
	logic [2:0]      word_reg,   word_next;
	logic [13:0]     col_reg,    col_next;
	logic            done_reg,   done_next;

	logic [13:0] row_addr;
	logic [13:0] col_start;
	logic [13:0] col_linear;
	logic [13:0] col_sub;

	assign row_addr  = cur_reg.addr[27:14];
	assign col_start = cur_reg.addr[13:0];
	assign col_linear = col_reg + 14'h0001;
	// sub-block order wraps inside the aligned block
	assign col_sub = (col_reg & ~`MEDC_SUBBLOCK_MASK)
		| ((col_reg + 14'h0001) & `MEDC_SUBBLOCK_MASK);

	always_comb begin
		state_next = state_reg;
		cur_next   = cur_reg;
		cnt_next   = cnt_reg;
		word_next  = word_reg;
		col_next   = col_reg;
		done_next  = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (req_valid_i) begin
					cur_next  = req_i;
					word_next = 3'h0;
					col_next  = req_i.addr[13:0];
					if (req_i.refresh) begin
						state_next = ST_REFRESH;
						cnt_next   = `MEDC_REFRESH_CYC;
					end else if (req_i.dram) begin
						state_next = ST_ROW;
						cnt_next   = `MEDC_RAS_TO_CAS_CYC;
					end else begin
						state_next = ST_MEM_SETUP;
						cnt_next   = `MEDC_MEM_SETUP_CYC;
					end
				end
			end
			ST_MEM_SETUP: begin
				if (cnt_reg <= 4'h1) begin
					state_next = ST_MEM_STROBE;
					cnt_next   = `MEDC_MEM_STROBE_CYC;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			ST_MEM_STROBE: begin
				if (mode_i == MEDC_MODE_SHARED && mem_wait) begin
					state_next = ST_MEM_SETUP; // RL4
					cnt_next   = `MEDC_MEM_SETUP_CYC;
				end else if (cnt_reg <= 4'h2) begin
					state_next = ST_MEM_LAST;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			ST_MEM_LAST: begin
				if (mode_i == MEDC_MODE_SHARED && mem_wait) begin
					state_next = ST_MEM_SETUP; // RL4
					cnt_next   = `MEDC_MEM_SETUP_CYC;
				end else if (mem_wait) begin
					state_next = ST_MEM_LAST; // RL3
				end else begin
					state_next = ST_IDLE;
					done_next  = 1'b1;
				end
			end
			ST_ROW: begin
				if (dram_wait && !sdram_mode_i) begin
					state_next = ST_ROW; // RL14
				end else if (cnt_reg <= 4'h1) begin
					state_next = ST_COL;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			ST_COL: begin
				if (!(dram_wait && !sdram_mode_i)) begin // RL14
					state_next = ST_CAS;
					cnt_next   = `MEDC_CAS_PULSE_CYC;
				end
			end
			ST_CAS: begin
				if (dram_wait && !sdram_mode_i) begin
					state_next = ST_CAS; // RL14
				end else if (cnt_reg > 4'h1) begin
					cnt_next = cnt_reg - 4'h1;
				end else if (word_reg == cur_reg.words) begin
					state_next = ST_PRECHARGE;
					cnt_next   = `MEDC_PRECHARGE_CYC;
				end else begin
					state_next = ST_COL;
					word_next  = word_reg + 3'h1;
					col_next   = cur_reg.subblock ? col_sub
						: col_linear; // RL7
				end
			end
			ST_PRECHARGE, ST_REFRESH: begin
				if (dram_wait && !sdram_mode_i) begin
					state_next = state_reg; // RL14
				end else if (cnt_reg <= 4'h1) begin
					state_next = ST_IDLE;
					done_next  = 1'b1;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin // RL18
		if (reset_i) begin
			state_reg <= ST_IDLE;
			cur_reg   <= '0;
			cnt_reg   <= 4'h0;
			word_reg  <= 3'h0;
			col_reg   <= 14'h0000;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			cur_reg   <= cur_next;
			cnt_reg   <= cnt_next;
			word_reg  <= word_next;
			col_reg   <= col_next;
			done_reg  <= done_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin decode, registered so every output leaves a flop
	logic             mem_oe_n_next;
	logic [LANES-1:0] mem_we_n_next;
	logic             mem_xcvr_oe_n_next;
	medc_dram_pins_s  dp_next;
	logic             dir_next;
	logic             dir_oe_next;
	logic             ready_next;
	logic             mem_act;
	logic             dram_act;

	logic             mem_oe_n_reg;
	logic [LANES-1:0] mem_we_n_reg;
	logic             mem_xcvr_oe_n_reg;
	medc_dram_pins_s  dp_reg;
	logic             dir_reg;
	logic             dir_oe_reg;
	logic             ready_reg;

	always_comb begin
		mem_act = state_next inside {ST_MEM_SETUP, ST_MEM_STROBE,
			ST_MEM_LAST};
		dram_act = state_next inside {ST_ROW, ST_COL, ST_CAS};
		mem_oe_n_next = ~(mem_act && state_next != ST_MEM_SETUP
			&& !cur_next.write); // RL1
		mem_xcvr_oe_n_next = ~mem_act; // RL5
		dp_next = '{ras_n: '1, cas_n: '1, we_n: 1'b1, oe_n: 1'b1,
			xcvr_oe_n: 1'b1, addr: row_addr};
		dp_next.addr = (state_next == ST_ROW) ? cur_next.addr[27:14]
			: col_next; // RL6
		if (dram_act || state_next == ST_REFRESH) begin
			dp_next.ras_n[cur_next.bank] = 1'b0; // RL8
		end
		if (state_next == ST_REFRESH) begin
			dp_next.cas_n = '0; // refresh: all column strobes fall on the same edge as the row strobe
			dp_next.we_n  = 1'b1; // RL10
		end else begin
			// early write: we set before the column strobe falls
			dp_next.we_n = ~(dram_act && cur_next.write); // RL11 RL15
		end
		if (state_next == ST_CAS) begin
			dp_next.cas_n = ~cur_next.lanes; // RL9
		end
		if (sdram_mode_i) begin
			dp_next.oe_n = ~(state_next == ST_ROW); // RL12
		end else begin
			dp_next.oe_n = ~(dram_act && !cur_next.write); // RL12
		end
		dp_next.xcvr_oe_n = ~dram_act; // RL13
		for (int i = 0; i < LANES; i++) begin
			mem_we_n_next[i] = ~(state_next inside {ST_MEM_STROBE,
				ST_MEM_LAST} && cur_next.write
				&& cur_next.lanes[i]); // RL2
		end
		dir_oe_next = (mem_act || dram_act) && cur_next.dma; // RL16 RL17
		dir_next    = dir_oe_next && !cur_next.write; // RL16
		ready_next  = (state_next == ST_IDLE);
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			mem_oe_n_reg      <= 1'b1;
			mem_we_n_reg      <= '1;
			mem_xcvr_oe_n_reg <= 1'b1;
			dp_reg            <= '{ras_n: '1, cas_n: '1, we_n: 1'b1,
				oe_n: 1'b1, xcvr_oe_n: 1'b1, addr: 14'h0000};
			dir_reg           <= 1'b0;
			dir_oe_reg        <= 1'b0;
			ready_reg         <= 1'b0;
		end else begin
			mem_oe_n_reg      <= mem_oe_n_next;
			mem_we_n_reg      <= mem_we_n_next;
			mem_xcvr_oe_n_reg <= mem_xcvr_oe_n_next;
			dp_reg            <= dp_next;
			dir_reg           <= dir_next;
			dir_oe_reg        <= dir_oe_next;
			ready_reg         <= ready_next;
		end
	end

	// ready_reg tracks the idle state, so the port leaves a flop directly
	assign req_ready_o      = ready_reg;
	assign done_o           = done_reg;
	assign mem_oe_n_o       = mem_oe_n_reg;
	assign mem_we_n_o       = mem_we_n_reg;
	assign mem_xcvr_oe_n_o  = mem_xcvr_oe_n_reg;
	assign dram_ras_n_o     = dp_reg.ras_n;
	assign dram_cas_n_o     = dp_reg.cas_n;
	assign dram_we_n_o      = dp_reg.we_n;
	assign dram_oe_n_o      = dp_reg.oe_n;
	assign dram_xcvr_oe_n_o = dp_reg.xcvr_oe_n;
	assign dram_addr_o      = dp_reg.addr;
	assign xcvr_direction_o    = dir_reg;
	assign xcvr_direction_oe_o = dir_oe_reg;

endmodule

// ===== design/medc_defs.svh
// timing counts and field positions for the memory and dram pin controller
`ifndef MEDC_DEFS_SVH
`define MEDC_DEFS_SVH

`define MEDC_CLK_PERIOD_NS      5
`define MEDC_ADDR_LSB           2
`define MEDC_ADDR_MSB           15
`define MEDC_LANES              4
`define MEDC_BANKS              4
`define MEDC_MEM_SETUP_CYC      4'h1
`define MEDC_MEM_STROBE_CYC     4'h2
`define MEDC_RAS_TO_CAS_CYC     4'h1
`define MEDC_CAS_PULSE_CYC      4'h1
`define MEDC_PRECHARGE_CYC      4'h2
`define MEDC_REFRESH_CYC        4'h3
`define MEDC_SUBBLOCK_MASK      14'h0003

`endif

// ===== design/medc_pkg.sv
// shared types for the memory and dram pin controller
package medc_pkg;

	typedef enum logic [1:0] {
		MEDC_MODE_PLAIN,
		MEDC_MODE_PERIPH_A,
		MEDC_MODE_PERIPH_B,
		MEDC_MODE_SHARED
	} medc_mode_e;

	typedef struct packed {
		logic        write;
		logic        dram;
		logic        refresh;
		logic        dma;
		logic        subblock;
		logic [1:0]  bank;
		logic [3:0]  lanes;
		logic [2:0]  words;
		logic [27:0] addr;
	} medc_req_s;

	typedef struct packed {
		logic [3:0]  ras_n;
		logic [3:0]  cas_n;
		logic        we_n;
		logic        oe_n;
		logic        xcvr_oe_n;
		logic [13:0] addr;
	} medc_dram_pins_s;

endpackage

// ===== design/medc_wait_sync.sv
// two-flop synchroniser for the active-low wait inputs
module medc_wait_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             ref_clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_n_i,
	output logic      [WIDTH-1:0] sync_n_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// idle level is high: nobody waiting
	always_comb begin
		meta_next = async_n_i;
		sync_next = meta_reg;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			meta_reg <= '1;
			sync_reg <= '1;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_n_o = sync_reg;

endmodule

// ===== tb/medc_ctrl_props.sv
// port checker for the memory and dram pin controller
module medc_ctrl_props
	import medc_pkg::*;
#(
	parameter int LANES = 4,
	parameter int BANKS = 4
) (
	input wire logic             ref_clk_i,
	input wire logic             reset_i,
	input wire logic             req_valid_i,
	input wire medc_req_s        req_i,
	input wire logic             req_ready_o,
	input wire logic             done_o,
	input wire logic             mem_wait_n_i,
	input wire logic             mem_oe_n_o,
	input wire logic [LANES-1:0] mem_we_n_o,
	input wire logic             mem_xcvr_oe_n_o,
	input wire logic [BANKS-1:0] dram_ras_n_o,
	input wire logic [LANES-1:0] dram_cas_n_o,
	input wire logic             dram_we_n_o,
	input wire logic             dram_xcvr_oe_n_o,
	input wire logic [13:0]      dram_addr_o,
	input wire logic             xcvr_direction_o,
	input wire logic             xcvr_direction_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic bk;
	logic dk;
	assign bk = req_valid_i && req_ready_o && !req_i.dram && !req_i.refresh;
	assign dk = req_valid_i && req_ready_o && req_i.dram && !req_i.refresh;

	done_pulse_a: assert property (done_o |-> req_ready_o ##1 !done_o)
		else $error("done held or ready missing");
	rd_strobe_a: assert property (bk && !req_i.write |->
		##2 !mem_oe_n_o && &mem_we_n_o) else $error("read strobe missing");
	wr_lane_a: assert property (bk && req_i.write |->
		##2 mem_we_n_o == ~$past(req_i.lanes, 2) && mem_oe_n_o)
		else $error("write lanes wrong");
	bank_xcvr_a: assert property (!mem_oe_n_o || !(&mem_we_n_o) |->
		!mem_xcvr_oe_n_o) else $error("bank transceiver off");
	bank_time_a: assert property (mem_wait_n_i[*2] ##0 bk
		##1 mem_wait_n_i[*3] |-> ##1 done_o) else $error("bank latency");
	row_addr_a: assert property (dk |=>
		dram_addr_o == $past(req_i.addr[27:14])
		&& dram_ras_n_o == ~(4'h1 << $past(req_i.bank)))
		else $error("row phase wrong");
	refresh_we_a: assert property (!(&dram_cas_n_o) && dram_xcvr_oe_n_o
		|-> dram_we_n_o) else $error("write enable low in refresh");
	one_bank_a: assert property (!dram_xcvr_oe_n_o |->
		$onehot(~dram_ras_n_o)) else $error("bank strobe not one-hot");
	early_wr_a: assert property ($fell(dram_cas_n_o[0]) && !dram_we_n_o
		|-> !$past(dram_we_n_o)) else $error("late write enable");
	dir_rel_a: assert property (!xcvr_direction_oe_o |->
		!xcvr_direction_o) else $error("direction set while released");
endmodule

bind medc_ctrl medc_ctrl_props #(.LANES(LANES), .BANKS(BANKS))
	u_medc_ctrl_props (.*);

// ===== tb/medc_mem_model.sv
// far side: banks and edo chips that stall a chosen number of cycles
module medc_mem_model (
	input  wire logic       ref_clk_i,
	input  wire logic [3:0] stall_i,
	input  wire logic [3:0] dstall_i,
	output logic            mem_wait_n_o,
	output logic            dram_wait_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] mcnt_reg = 4'h0;
	logic [3:0] dcnt_reg = 4'h0;
	logic       mw_n_reg = 1'b1;
	logic       dw_n_reg = 1'b1;
	logic       mhit;
	logic       dhit;
	// stall is bounded so a busy restart cannot loop forever
	assign mhit = mcnt_reg < stall_i;
	assign dhit = dcnt_reg < dstall_i;
	assign mem_wait_n_o = mw_n_reg;
	assign dram_wait_n_o = dw_n_reg;
	always @(posedge ref_clk_i) begin
		mcnt_reg <= (stall_i == 4'h0) ? 4'h0 : mcnt_reg + {3'h0, mhit};
		dcnt_reg <= (dstall_i == 4'h0) ? 4'h0 : dcnt_reg + {3'h0, dhit};
		mw_n_reg <= !mhit;
		dw_n_reg <= !dhit;
	end
endmodule

// ===== tb/tb.sv
// self-checking bench for the memory and dram pin controller
module tb
	import medc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
`define CHK(a, e) begin \
	num_checks++; \
	if ((a) !== (e)) begin \
		fails++; \
		$display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (e)); \
	end \
end
	logic        ref_clk_i, reset_i, sdram_mode_i, req_valid_i;
	medc_mode_e  mode_i;
	medc_req_s   req_i;
	logic        req_ready_o, done_o, mem_wait_n_i, dram_wait_n_i;
	logic        mem_oe_n_o, mem_xcvr_oe_n_o, dram_we_n_o, dram_oe_n_o;
	logic        dram_xcvr_oe_n_o, xcvr_direction_o, xcvr_direction_oe_o;
	logic [3:0]  mem_we_n_o, dram_ras_n_o, dram_cas_n_o, stall, dstall;
	logic [3:0]  we_seen, cas_v, ref_cas;
	logic [13:0] dram_addr_o;
	logic [13:0] cols[$];
	logic        seen_oe, seen_doe, seen_dxo, dir_oe, dir_val, cas_we, ref_we;
	int          fails, num_checks, n, cyc;

	medc_ctrl u_medc_ctrl (.*);
	medc_mem_model u_medc_mem_model (.ref_clk_i, .stall_i(stall),
		.dstall_i(dstall), .mem_wait_n_o(mem_wait_n_i),
		.dram_wait_n_o(dram_wait_n_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// flags: {write, dram, refresh, dma, subblock}; bank 2, column 6
	function automatic medc_req_s rq(logic [4:0] f, logic [3:0] l,
		logic [2:0] w);
		return '{f[4], f[3], f[2], f[1], f[0], 2'h2, l, w, 28'h0A50006};
	endfunction

	task automatic run(input medc_req_s r, input medc_mode_e m,
		input logic [3:0] s, input logic [3:0] ds, input logic sd);
		@(posedge ref_clk_i);
		req_i <= r;
		req_valid_i <= 1'b1;
		mode_i <= m;
		stall <= s;
		dstall <= ds;
		sdram_mode_i <= sd;
		// ready is looked at mid-cycle, away from the edge that moves it
		@(negedge ref_clk_i);
		while (req_ready_o !== 1'b1)
			@(negedge ref_clk_i);
		@(posedge ref_clk_i);
		req_valid_i <= 1'b0;
		{n, seen_oe, seen_doe, seen_dxo, dir_oe, dir_val} = '0;
		{we_seen, ref_cas, ref_we} = 9'h1FF;
		cols.delete();
		// first look follows the take edge: a one-cycle row phase shows there
		do begin
			if (n != 0)
				@(posedge ref_clk_i);
			#1;
			n++;
			seen_oe |= !mem_oe_n_o;
			we_seen &= mem_we_n_o;
			seen_doe |= !dram_oe_n_o;
			seen_dxo |= !dram_xcvr_oe_n_o;
			dir_oe |= xcvr_direction_oe_o;
			if (xcvr_direction_oe_o)
				dir_val = xcvr_direction_o;
			if (dram_cas_n_o != 4'hF && dram_xcvr_oe_n_o) begin
				ref_cas = dram_cas_n_o;
				ref_we &= dram_we_n_o;
			end
			if (dram_cas_n_o != 4'hF && !dram_xcvr_oe_n_o) begin
				cas_v = dram_cas_n_o;
				cas_we = dram_we_n_o;
				if (cols.size() == 0 || cols[$] !== dram_addr_o)
					cols.push_back(dram_addr_o);
			end
		end while (done_o !== 1'b1 && n < 200);
		@(posedge ref_clk_i);
		stall <= 4'h0;
		dstall <= 4'h0;
	endtask

	task automatic t_bank();
		for (int m = 0; m < 4; m++) begin
			run(rq(5'h00, 4'hF, 3'h0), medc_mode_e'(m), 4'h0, 4'h0, 1'b0);
			`CHK(n, 4)
			`CHK(seen_oe, 1'b1)
			run(rq(5'h10, 4'h5, 3'h0), medc_mode_e'(m), 4'h0, 4'h0, 1'b0);
			`CHK(we_seen, 4'hA)
			`CHK(seen_oe, 1'b0)
			run(rq(5'h00, 4'hF, 3'h0), medc_mode_e'(m), 4'h3, 4'h0, 1'b0);
			`CHK(n > 4, 1'b1)
		end
	endtask

	task automatic t_dram();
		logic [13:0] lin[4] = '{14'h0006, 14'h0007, 14'h0008, 14'h0009};
		logic [13:0] sub[4] = '{14'h0006, 14'h0007, 14'h0004, 14'h0005};
		run(rq(5'h08, 4'hF, 3'h3), MEDC_MODE_PLAIN, 4'h0, 4'h0, 1'b0);
		foreach (lin[i]) `CHK(cols[i], lin[i])
		`CHK(cas_we, 1'b1)
		`CHK(seen_doe, 1'b1)
		`CHK(seen_dxo, 1'b1)
		run(rq(5'h19, 4'h3, 3'h3), MEDC_MODE_PLAIN, 4'h0, 4'h0, 1'b0);
		foreach (sub[i]) `CHK(cols[i], sub[i])
		`CHK(cas_v, 4'hC)
		`CHK(cas_we, 1'b0)
		`CHK(seen_doe, 1'b0)
	endtask

	task automatic t_wait();
		int n0;
		run(rq(5'h04, 4'hF, 3'h0), MEDC_MODE_PLAIN, 4'h0, 4'h0, 1'b0);
		`CHK(ref_cas, 4'h0)
		`CHK(ref_we, 1'b1)
		run(rq(5'h08, 4'hF, 3'h0), MEDC_MODE_PLAIN, 4'h0, 4'h0, 1'b0);
		n0 = n;
		run(rq(5'h08, 4'hF, 3'h0), MEDC_MODE_PLAIN, 4'h0, 4'h4, 1'b0);
		`CHK(n > n0, 1'b1)
		run(rq(5'h08, 4'hF, 3'h0), MEDC_MODE_PLAIN, 4'h0, 4'h4, 1'b1);
		`CHK(n, n0)
		`CHK(seen_doe, 1'b1)
		run(rq(5'h18, 4'hF, 3'h0), MEDC_MODE_PLAIN, 4'h0, 4'h0, 1'b1);
		`CHK(cas_we, 1'b0)
	endtask

	task automatic t_dma();
		run(rq(5'h02, 4'hF, 3'h0), MEDC_MODE_PLAIN, 4'h0, 4'h0, 1'b0);
		`CHK({dir_oe, dir_val}, 2'h3)
		run(rq(5'h12, 4'hF, 3'h0), MEDC_MODE_PLAIN, 4'h0, 4'h0, 1'b0);
		`CHK({dir_oe, dir_val}, 2'h2)
		run(rq(5'h00, 4'hF, 3'h0), MEDC_MODE_PLAIN, 4'h0, 4'h0, 1'b0);
		`CHK(dir_oe, 1'b0)
	endtask

	initial begin
		{reset_i, req_valid_i, sdram_mode_i, stall, dstall} = 11'h400;
		req_i = '0;
		mode_i = MEDC_MODE_PLAIN;
		repeat (10) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		t_bank();
		t_dram();
		t_wait();
		t_dma();
		close_out();
	end
endmodule
